// >>> cassette_xfer_consts.vh
`ifndef CASSETTE_XFER_CONSTS_VH
`define CASSETTE_XFER_CONSTS_VH
// Register byte addresses
`define ADDR_CTRL        4'h0
`define ADDR_STATUS      4'h4
`define ADDR_CONFIG      4'h8
`define ADDR_DISPLAY     4'hc
// Control register fields (write starts a command)
`define CTRL_CMD_LSB     0
`define CTRL_CMD_MSB     2
`define CTRL_SEL_LSB     8
`define CTRL_SEL_MSB     14
// Command codes
`define CMD_NONE         3'h0
`define CMD_WRITE        3'h1
`define CMD_READ         3'h2
`define CMD_COMPARE      3'h3
`define CMD_FORMAT       3'h4
// Config register fields
`define CFG_PW_EN        0
`define CFG_NO_DUP       1
`define CFG_NO_OVR       2
`define CFG_EXT_PW       3
`define CFG_RESET        4'h0
// Status register fields
`define ST_BUSY          0
`define ST_DONE          1
`define ST_FAIL          2
`define ST_REJECT        3
`define ST_AUTO_DONE     4
`define ST_MODE_LSB      8
// Operating modes
`define MODE_PROGRAM     2'h0
`define MODE_MONITOR     2'h1
`define MODE_RUN         2'h2
// Display codes
`define DISP_BLANK       8'hff
`define DISP_END         8'he0
`define DISP_ERR         8'hee
// Timing
`define CLK_HZ           20000000
`define SHOW_TIME_S      5
`define SHOW_CYCLES      (`CLK_HZ * `SHOW_TIME_S)
`define FLASH_CYCLES     (`CLK_HZ / 4)
`define ALL_AREAS        7'h7f
`endif

// >>> cassette_xfer_ctrl.v
// Our own choices: register access over Avalon-MM and the register addresses.
`include "cassette_xfer_consts.vh"

module cassette_xfer_ctrl #(
   parameter AREAS       = 7,
   parameter WORD_COUNT  = 16,
   parameter SHOW_CYCLES = `SHOW_CYCLES,
   parameter FLASH_CYC   = `FLASH_CYCLES,
   parameter EXT_PW_OK   = 1'b0
) (
   // Clock and reset
   input  wire        CLOCK,
   input  wire        RST,
   // Avalon-MM slave
   input  wire [3:0]  AVS_ADDRESS,
   input  wire        AVS_READ,
   input  wire        AVS_WRITE,
   input  wire [31:0] AVS_WRITEDATA,
   output reg  [31:0] AVS_READDATA,
   output reg         AVS_WAITREQUEST,
   // Switches and cassette presence
   input  wire        WRITE_PROTECT_SWITCH,
   input  wire        STARTUP_LOAD_SWITCH,
   input  wire        CASSETTE_PRESENT,
   input  wire        CASSETTE_EXT_PW,
   input  wire [6:0]  CASSETTE_VALID,
   // Operating mode request
   input  wire [1:0]  MODE_REQ,
   output reg  [1:0]  MODE,
   // Word stream to memories
   output reg         MEM_REQ,
   output reg         MEM_WE_CASSETTE,
   output reg         MEM_WE_INTERNAL,
   output reg         MEM_ERASE,
   output reg  [2:0]  MEM_AREA,
   output reg  [15:0] MEM_ADDR,
   input  wire        MEM_MISMATCH,
   input  wire        MEM_ERROR,
   // Indicators and analog
   input  wire        IO_HOLD_FLAG,
   input  wire [11:0] ANALOG_IN,
   output reg  [11:0] ANALOG_OUT,
   output reg         ANALOG_CTRL_EN,
   output reg         BACKUP_ACTIVITY_INDICATOR,
   output reg  [7:0]  SEG_DISPLAY
);

   localparam S_IDLE = 2'h0;
   localparam S_RUN  = 2'h1;
   localparam S_SHOW = 2'h2;

   reg [1:0]  state_r;
   reg [2:0]  cmd_r;
   reg [6:0]  mask_r;
   reg [2:0]  area_r;
   reg [15:0] addr_r;
   reg [3:0]  cfg_r;
   reg        done_r;
   reg        fail_r;
   reg        reject_r;
   // Power-up values: armed at power-on, never touched by warm reset
   reg        auto_done_r  = 1'b0;
   reg        auto_armed_r = 1'b1;
   reg        boot_r;
   reg        held_r;
   reg [11:0] hold_val_r;
   reg [31:0] show_cnt_r;
   reg [31:0] flash_cnt_r;
   reg        flash_on_r;
   reg [7:0]  show_code_r;
   reg        is_auto_r;

   wire [2:0] cmd_in = AVS_WRITEDATA[`CTRL_CMD_MSB:`CTRL_CMD_LSB];
   wire [6:0] sel_in = AVS_WRITEDATA[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
   wire       wr_ctrl = AVS_WRITE && !AVS_WAITREQUEST &&
                        AVS_ADDRESS == `ADDR_CTRL;
   wire       pw_en  = cfg_r[`CFG_PW_EN];
   wire       up_ok  = !(pw_en && cfg_r[`CFG_NO_DUP]);
   wire       dn_ok  = !WRITE_PROTECT_SWITCH &&
                       !(pw_en && cfg_r[`CFG_NO_OVR]);
   wire       cmd_ok = (cmd_in == `CMD_WRITE && up_ok) ||
                       (cmd_in == `CMD_READ && dn_ok) ||
                       cmd_in == `CMD_COMPARE || cmd_in == `CMD_FORMAT;
   wire       accept = wr_ctrl && state_r == S_IDLE &&
                       MODE == `MODE_PROGRAM &&
                       CASSETTE_PRESENT && cmd_ok;
   // Startup load needs program image, no unsupported passwords
   wire       auto_ok = CASSETTE_PRESENT && CASSETTE_VALID[0] &&
                        !WRITE_PROTECT_SWITCH &&
                        !(CASSETTE_EXT_PW && !EXT_PW_OK);
   wire       area_on = mask_r[area_r];
   wire       last_w  = addr_r == WORD_COUNT - 1;
   wire       last_a  = area_r == AREAS - 1;
   wire       fault   = MEM_ERROR || !CASSETTE_PRESENT ||
                        (cmd_r == `CMD_COMPARE && MEM_MISMATCH);
   wire [31:0] total  = AREAS * WORD_COUNT;
   wire [31:0] done_w = area_r * WORD_COUNT + addr_r;
   wire [31:0] pct    = ((total - done_w) * 100) / total;

   always @(posedge CLOCK) begin
      if (RST) begin
         state_r         <= S_IDLE;
         cmd_r           <= `CMD_NONE;
         mask_r          <= 7'h00;
         area_r          <= 3'h0;
         addr_r          <= 16'h0000;
         cfg_r           <= `CFG_RESET;
         done_r          <= 1'b0;
         fail_r          <= 1'b0;
         reject_r        <= 1'b0;
         is_auto_r       <= 1'b0;
         boot_r          <= 1'b1;
         held_r          <= 1'b0;
         hold_val_r      <= 12'h000;
         show_cnt_r      <= 32'h0;
         flash_cnt_r     <= 32'h0;
         flash_on_r      <= 1'b0;
         show_code_r     <= `DISP_BLANK;
         MODE            <= `MODE_PROGRAM;
         MEM_REQ         <= 1'b0;
         MEM_WE_CASSETTE <= 1'b0;
         MEM_WE_INTERNAL <= 1'b0;
         MEM_ERASE       <= 1'b0;
         MEM_AREA        <= 3'h0;
         MEM_ADDR        <= 16'h0000;
         ANALOG_OUT      <= 12'h000;
         ANALOG_CTRL_EN  <= 1'b0;
         BACKUP_ACTIVITY_INDICATOR <= 1'b0;
         SEG_DISPLAY     <= `DISP_BLANK;
      end else begin
         boot_r <= 1'b0;
         // Mode changes refused while an operation runs
         if (state_r != S_RUN)
            MODE <= MODE_REQ;
         if (AVS_WRITE && !AVS_WAITREQUEST &&
             AVS_ADDRESS == `ADDR_CONFIG)
            cfg_r <= AVS_WRITEDATA[3:0];
         if (wr_ctrl)
            reject_r <= !accept;
         // Analog control: stopped during operation, hold restored after
         if (state_r == S_RUN) begin
            ANALOG_CTRL_EN <= 1'b0;
            ANALOG_OUT     <= 12'h000;
         end else if (held_r) begin
            ANALOG_CTRL_EN <= 1'b1;
            ANALOG_OUT     <= hold_val_r;
            held_r         <= IO_HOLD_FLAG;
         end else begin
            ANALOG_CTRL_EN <= 1'b1;
            ANALOG_OUT     <= ANALOG_IN;
         end
         MEM_REQ         <= 1'b0;
         MEM_WE_CASSETTE <= 1'b0;
         MEM_WE_INTERNAL <= 1'b0;
         MEM_ERASE       <= 1'b0;
         case (state_r)
            S_IDLE: begin
               // Startup load only on the first cycle after reset
               if (boot_r && STARTUP_LOAD_SWITCH && auto_armed_r) begin
                  if (auto_ok) begin
                     cmd_r  <= `CMD_READ;
                     mask_r <= CASSETTE_VALID;
                     is_auto_r <= 1'b1;
                     state_r <= S_RUN;
                  end else begin
                     fail_r <= 1'b1;
                     show_code_r <= `DISP_ERR;
                     state_r <= S_SHOW;
                  end
               end else if (accept) begin
                  cmd_r <= cmd_in;
                  is_auto_r <= 1'b0;
                  if (cmd_in == `CMD_COMPARE || cmd_in == `CMD_FORMAT)
                     mask_r <= `ALL_AREAS;
                  else
                     mask_r <= sel_in;
                  done_r <= 1'b0;
                  fail_r <= 1'b0;
                  state_r <= S_RUN;
               end
               if ((boot_r && STARTUP_LOAD_SWITCH && auto_armed_r) || accept)
               begin
                  area_r <= 3'h0;
                  addr_r <= 16'h0000;
                  held_r <= IO_HOLD_FLAG;
                  hold_val_r <= ANALOG_OUT;
               end
            end
            S_RUN: begin
               BACKUP_ACTIVITY_INDICATOR <= 1'b1;
               SEG_DISPLAY <= pct[7:0];
               if (fault && MEM_REQ) begin
                  fail_r <= 1'b1;
                  show_code_r <= `DISP_ERR;
                  state_r <= S_SHOW;
               end else begin
                  if (area_on) begin
                     MEM_REQ  <= 1'b1;
                     MEM_AREA <= area_r;
                     MEM_ADDR <= addr_r;
                     MEM_WE_CASSETTE <= cmd_r == `CMD_WRITE;
                     MEM_WE_INTERNAL <= cmd_r == `CMD_READ;
                     MEM_ERASE       <= cmd_r == `CMD_FORMAT;
                  end
                  if (!area_on || last_w) begin
                     addr_r <= 16'h0000;
                     area_r <= area_r + 3'h1;
                     if (last_a) begin
                        done_r <= 1'b1;
                        show_code_r <= `DISP_END;
                        state_r <= S_SHOW;
                     end
                  end else
                     addr_r <= addr_r + 16'h0001;
               end
               show_cnt_r  <= 32'h0;
               flash_cnt_r <= 32'h0;
               flash_on_r  <= 1'b1;
            end
            S_SHOW: begin
               BACKUP_ACTIVITY_INDICATOR <= 1'b0;
               // Last word is answered after the run state has ended
               if (MEM_REQ && fault) begin
                  done_r      <= 1'b0;
                  fail_r      <= 1'b1;
                  show_code_r <= `DISP_ERR;
               end
               SEG_DISPLAY <= flash_on_r ? show_code_r : `DISP_BLANK;
               if (flash_cnt_r == FLASH_CYC - 1) begin
                  flash_cnt_r <= 32'h0;
                  flash_on_r  <= !flash_on_r;
               end else
                  flash_cnt_r <= flash_cnt_r + 32'h1;
               if (show_cnt_r == SHOW_CYCLES - 1) begin
                  SEG_DISPLAY <= `DISP_BLANK;
                  state_r <= S_IDLE;
               end else
                  show_cnt_r <= show_cnt_r + 32'h1;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // Startup-load latch survives warm reset; re-armed only with switch off, cleared when the startup load runs
   always @(posedge CLOCK) begin
      if (!STARTUP_LOAD_SWITCH)
         auto_armed_r <= 1'b1;
      else if (state_r == S_RUN && is_auto_r)
         auto_armed_r <= 1'b0;
      auto_done_r <= !auto_armed_r;
   end

   // Bus slave: one wait cycle per access, then answer
   always @(posedge CLOCK) begin
      if (RST) begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA    <= 32'h0;
      end else begin
         AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
         if (AVS_READ && AVS_WAITREQUEST) begin
            case (AVS_ADDRESS)
               `ADDR_CTRL:    AVS_READDATA <= {17'h0, mask_r, 5'h0, cmd_r};
               `ADDR_STATUS:  AVS_READDATA <= {22'h0, MODE, 3'h0,
                                 auto_done_r, reject_r, fail_r, done_r,
                                 state_r == S_RUN};
               `ADDR_CONFIG:  AVS_READDATA <= {28'h0, cfg_r};
               `ADDR_DISPLAY: AVS_READDATA <= {24'h0, SEG_DISPLAY};
               default:       AVS_READDATA <= 32'h0;
            endcase
         end
      end
   end

endmodule // cassette_xfer_ctrl

// >>> cassette_xfer_monitor.sv
`include "cassette_xfer_consts.vh"
module cassette_xfer_monitor #(
   parameter SHOW_CYCLES = 50
) (
   // Clock and reset
   input wire        CLOCK,
   input wire        RST,
   // Bus handshake
   input wire        AVS_READ,
   input wire        AVS_WRITE,
   input wire        AVS_WAITREQUEST,
   // Switches and mode
   input wire        CASSETTE_PRESENT,
   input wire        WRITE_PROTECT_SWITCH,
   input wire [1:0]  MODE,
   // Activity
   input wire        MEM_REQ,
   input wire        MEM_WE_INTERNAL,
   input wire        ANALOG_CTRL_EN,
   input wire        BACKUP_ACTIVITY_INDICATOR,
   input wire [7:0]  SEG_DISPLAY
);
   logic [31:0] idle_r;
   wire         act = BACKUP_ACTIVITY_INDICATOR;
   // Bus writes restart the count too, though a refused bus command never flashes
   always @(posedge CLOCK)
      if (RST || act || (AVS_WRITE && !AVS_WAITREQUEST)) idle_r <= 32'h0;
      else if (idle_r != 32'hffffffff) idle_r <= idle_r + 32'h1;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   sequence s_taken; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST; endsequence
   sequence s_answer; !AVS_WAITREQUEST ##1 AVS_WAITREQUEST; endsequence
   property p_answer; s_taken |=> s_answer; endproperty
   property p_req; MEM_REQ |-> act; endproperty
   property p_analog; act && $past(act) |-> !ANALOG_CTRL_EN; endproperty
   property p_mode; act |-> MODE == `MODE_PROGRAM; endproperty
   property p_start; $rose(act) |-> $past(MODE) == `MODE_PROGRAM; endproperty
   property p_present; $rose(act) |-> $past(CASSETTE_PRESENT); endproperty
   property p_wp; MEM_REQ && WRITE_PROTECT_SWITCH |-> !MEM_WE_INTERNAL;
   endproperty
   property p_pct; act && $past(act) |-> SEG_DISPLAY <= 8'h64; endproperty
   property p_code; $fell(act) |->
      ##[0:8] (SEG_DISPLAY == `DISP_END || SEG_DISPLAY == `DISP_ERR);
   endproperty
   property p_blank; idle_r > SHOW_CYCLES + 8 |-> SEG_DISPLAY == `DISP_BLANK;
   endproperty
   a_answer: assert property (p_answer) else $error("bus answer late");
   a_req: assert property (p_req) else $error("word without activity");
   a_analog: assert property (p_analog) else $error("analog active");
   a_mode: assert property (p_mode) else $error("mode left program");
   a_start: assert property (p_start) else $error("start outside program");
   a_present: assert property (p_present) else $error("start no cassette");
   a_wp: assert property (p_wp) else $error("write despite protect");
   a_pct: assert property (p_pct) else $error("progress over 100");
   a_code: assert property (p_code) else $error("no end code");
   a_blank: assert property (p_blank) else $error("display not blank");
endmodule // cassette_xfer_monitor

bind cassette_xfer_ctrl cassette_xfer_monitor #(.SHOW_CYCLES(SHOW_CYCLES)) mon (
   .CLOCK(CLOCK), .RST(RST), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .CASSETTE_PRESENT(CASSETTE_PRESENT),
   .WRITE_PROTECT_SWITCH(WRITE_PROTECT_SWITCH), .MODE(MODE),
   .MEM_REQ(MEM_REQ), .MEM_WE_INTERNAL(MEM_WE_INTERNAL),
   .ANALOG_CTRL_EN(ANALOG_CTRL_EN), .SEG_DISPLAY(SEG_DISPLAY),
   .BACKUP_ACTIVITY_INDICATOR(BACKUP_ACTIVITY_INDICATOR));

// >>> cassette_model.sv
module cassette_model (
   // Word stream
   input wire        clock,
   input wire        mem_req,
   input wire        we_cassette,
   input wire        we_internal,
   input wire        erase,
   input wire [2:0]  area,
   // Bench control
   input wire        fail,
   input wire        clear,
   input wire [6:0]  valid_in,
   // Answers
   output logic        mismatch,
   output logic        error,
   output logic [6:0]  valid,
   output logic [6:0]  seen = 7'h0,
   output logic [2:0]  kind = 3'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic toggle_r = 1'b0;
   always @(posedge clock) begin
      toggle_r <= ~toggle_r;
      if (clear) begin
         seen <= 7'h0;
         kind <= 3'h0;
      end else if (mem_req) begin
         seen[area] <= 1'b1;
         kind <= kind | {erase, we_internal, we_cassette};
      end
   end
   // Between words the answer lines wander, never hold
   assign error    = mem_req ? fail : toggle_r;
   assign mismatch = mem_req ? fail : ~toggle_r;
   assign valid    = valid_in | 7'h01;
endmodule // cassette_model

// >>> removable_cassette_transfer_ctrl_tb_top.sv
`include "cassette_xfer_consts.vh"
module removable_cassette_transfer_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock, rst, rd_r, wr_r, wp, sls, present, ext_pw, hold, fail;
   logic        clear, waitreq, mreq, mwc, mwi, mer, mism, merr, actl, ind;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata, eq[$], mq[$];
   logic [1:0]  mode_req, mode;
   logic [2:0]  area, kind;
   logic [15:0] maddr, lfsr_r;
   logic [6:0]  valid_in, valid, seen, s;
   logic [11:0] ain, aout, held;
   logic [7:0]  seg;
   int          errors, n_tests, cyc;
   cassette_xfer_ctrl #(.SHOW_CYCLES(50), .FLASH_CYC(5), .WORD_COUNT(4)) dut (
      .CLOCK(clock), .RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd_r),
      .AVS_WRITE(wr_r), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(waitreq), .WRITE_PROTECT_SWITCH(wp),
      .STARTUP_LOAD_SWITCH(sls), .CASSETTE_PRESENT(present),
      .CASSETTE_EXT_PW(ext_pw), .CASSETTE_VALID(valid), .MODE_REQ(mode_req),
      .MODE(mode), .MEM_REQ(mreq), .MEM_WE_CASSETTE(mwc), .MEM_WE_INTERNAL(mwi),
      .MEM_ERASE(mer), .MEM_AREA(area), .MEM_ADDR(maddr), .MEM_MISMATCH(mism),
      .MEM_ERROR(merr), .IO_HOLD_FLAG(hold), .ANALOG_IN(ain), .ANALOG_OUT(aout),
      .ANALOG_CTRL_EN(actl), .BACKUP_ACTIVITY_INDICATOR(ind), .SEG_DISPLAY(seg));
   cassette_model cas (.clock(clock), .mem_req(mreq), .we_cassette(mwc),
      .we_internal(mwi), .erase(mer), .area(area), .fail(fail), .clear(clear),
      .valid_in(valid_in), .mismatch(mism), .error(merr), .valid(valid),
      .seen(seen), .kind(kind));
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task chk(input string nm, input logic [31:0] sv, input logic [31:0] ev);
      n_tests++;
      if (sv !== ev) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, ev, sv);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_r <= w;
      rd_r <= !w;
      @(posedge clock);
      while (waitreq !== 1'b0) @(posedge clock);
      wr_r <= 1'b0;
      rd_r <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      eq.push_back(e);
      mq.push_back(m);
      bus(1'b0, a, 32'h0);
   endtask
   task cmd(input logic [2:0] c, input logic [6:0] sl);
      bus(1'b1, `ADDR_CTRL, {17'h0, sl, 5'h0, c});
   endtask
   task rej(input logic [2:0] c);
      cmd(c, 7'h01);
      rd(`ADDR_STATUS, 32'h8, 32'h8);
   endtask
   task wait_done;
      repeat (3) @(posedge clock);
      while (ind === 1'b1) @(posedge clock);
   endtask
   task show(input logic [7:0] code);
      logic f;
      f = 1'b0;
      repeat (12) begin
         @(posedge clock);
         if (seg === code) f = 1'b1;
      end
      chk("display", {31'h0, f}, 32'h1);
   endtask
   task do_rst;
      rst <= 1'b1;
      clear <= 1'b1;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      clear <= 1'b0;
   endtask
   task op(input logic [2:0] c, input logic [6:0] sl, input logic [6:0] m,
           input logic [2:0] k);
      clear <= 1'b1;
      @(posedge clock);
      clear <= 1'b0;
      cmd(c, sl);
      wait_done;
      chk("areas", {25'h0, seen}, {25'h0, m});
      chk("kind", {29'h0, kind}, {29'h0, k});
      show(`DISP_END);
      repeat (60) @(posedge clock);
   endtask
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // Read data is judged where it lands, against the oldest note
   always @(posedge clock) begin
      if (rd_r && waitreq === 1'b0 && eq.size() > 0) begin
         chk("readdata", rdata & mq[0], eq[0]);
         void'(eq.pop_front());
         void'(mq.pop_front());
      end
      cyc++;
      if (cyc == 20000) begin
         errors++;
         report_and_stop;
      end
   end
   initial begin
      {rst, rd_r, wr_r, addr, wdata, wp, fail, clear, ext_pw, mode_req} = '0;
      {sls, present, hold} = 3'h7;
      valid_in = 7'h24;
      ain = 12'h5a5;
      lfsr_r = 16'h7050;
      do_rst;
      wait_done;
      chk("areas", {25'h0, seen}, 32'h25);
      chk("kind", {29'h0, kind}, 32'h2);
      rd(`ADDR_STATUS, 32'h10, 32'h10);
      repeat (60) @(posedge clock);
      do_rst;
      repeat (20) @(posedge clock);
      chk("areas", {25'h0, seen}, 32'h0);
      sls <= 1'b0;
      do_rst;
      repeat (2) @(posedge clock);
      sls <= 1'b1;
      ext_pw <= 1'b1;
      do_rst;
      show(`DISP_ERR);
      chk("areas", {25'h0, seen}, 32'h0);
      {sls, ext_pw} <= 2'h0;
      valid_in <= 7'h7f;
      repeat (60) @(posedge clock);
      for (int c = 1; c <= 4; c++) begin
         lfsr_r = lfsr(lfsr_r);
         s = lfsr_r[6:0] | 7'h01;
         held = aout;
         ain <= lfsr_r[15:4];
         op(c[2:0], s, c < 3 ? s : 7'h7f,
            c == 3 ? 3'h0 : (c == 4 ? 3'h4 : c[2:0]));
         chk("analog", {20'h0, aout}, {20'h0, held});
      end
      cmd(`CMD_WRITE, 7'h7f);
      rej(`CMD_WRITE);
      wait_done;
      repeat (60) @(posedge clock);
      for (int m = 1; m <= 2; m++) begin
         cmd(`CMD_FORMAT, 7'h01);
         mode_req <= m[1:0];
         repeat (4) @(posedge clock);
         chk("mode", {30'h0, mode}, 32'h0);
         wait_done;
         repeat (64) @(posedge clock);
         chk("mode", {30'h0, mode}, m);
         rej(`CMD_WRITE);
         mode_req <= `MODE_PROGRAM;
         repeat (4) @(posedge clock);
      end
      present <= 1'b0;
      rej(`CMD_COMPARE);
      present <= 1'b1;
      wp <= 1'b1;
      rej(`CMD_READ);
      wp <= 1'b0;
      bus(1'b1, `ADDR_CONFIG, 32'h3);
      rej(`CMD_WRITE);
      bus(1'b1, `ADDR_CONFIG, 32'h5);
      rd(`ADDR_CONFIG, 32'h7, 32'h5);
      rej(`CMD_READ);
      wp <= 1'b1;
      op(`CMD_WRITE, 7'h0a, 7'h0a, 3'h1);
      wp <= 1'b0;
      bus(1'b1, `ADDR_CONFIG, 32'h0);
      fail <= 1'b1;
      cmd(`CMD_WRITE, 7'h01);
      wait_done;
      show(`DISP_ERR);
      fail <= 1'b0;
      repeat (60) @(posedge clock);
      report_and_stop;
   end
endmodule // removable_cassette_transfer_ctrl_tb_top
